// >>> rtl/irxmf_pkg.sv
package irxmf_pkg;

  // context count and register map
  localparam int IRXMF_NCTX = 8;
  localparam logic [15:0] IRXMF_PTR_BASE = 16'h040c;
  localparam logic [15:0] IRXMF_MATCH_BASE = 16'h410c;
  localparam logic [15:0] IRXMF_STRIDE = 16'h0020;

  // match register layout
  localparam int IRXMF_TAG_LSB = 28;
  localparam int IRXMF_TAG_THREE_BIT = 31;
  localparam int IRXMF_TAG_TWO_BIT = 30;
  localparam int IRXMF_TAG_ONE_BIT = 29;
  localparam int IRXMF_TAG_ZERO_BIT = 28;
  localparam int IRXMF_CMP_MSB = 24;
  localparam int IRXMF_CMP_LSB = 12;
  localparam int IRXMF_QUAL_MSB = 11;
  localparam int IRXMF_QUAL_LSB = 8;
  localparam int IRXMF_ACCEPT_TAG_ONE_GATE_BIT = 6;
  localparam int IRXMF_CHAN_MSB = 5;
  localparam int IRXMF_CHAN_LSB = 0;

  // writable bits of the match register; bits 27:25 and 7 read as zero
  localparam logic [31:0] IRXMF_MATCH_RMASK = 32'hf1ff_ff7f;
  localparam logic [31:0] IRXMF_MATCH_RESET = 32'h0000_0000;
  localparam logic [31:0] IRXMF_PTR_RESET = 32'h0000_0000;
  localparam logic [31:0] IRXMF_RDATA_IDLE = 32'h0000_0000;

  // tag and qualifier encodings
  localparam logic [1:0] IRXMF_QSEL_COMPARE = 2'h3;
  localparam logic [1:0] IRXMF_TAG_ONE = 2'h1;
  localparam logic [1:0] IRXMF_SYNC_TOP_OK = 2'h0;

  // one received isochronous packet header
  typedef struct packed {
    logic valid;
    logic [1:0] tag;
    logic [5:0] chan;
    logic [3:0] sync;
  } irxmf_pkt_t;

  // low seconds bits and tick count of the bus cycle timer
  typedef struct packed {
    logic [1:0] seconds_low;
    logic [12:0] ticks;
  } irxmf_ctime_t;

endpackage : irxmf_pkg

// >>> rtl/irxmf_ctx_filter.sv
`timescale 1ns/100ps
module irxmf_ctx_filter
  import irxmf_pkg::*;
(
  input wire logic [31:0] i_match,
  input wire irxmf_pkt_t i_pkt,
  input wire logic [1:0] i_qual_sel,
  output logic o_pass
);

  logic chan_ok;
  logic tag_ok;
  logic tag_one_blocked;
  logic qual_ok;

  // channel, tag, tag-one qualifier and header qualifier checks
  always_comb begin
    chan_ok = (i_pkt.chan == i_match[IRXMF_CHAN_MSB:IRXMF_CHAN_LSB]);
    tag_ok = i_match[IRXMF_TAG_LSB + int'(i_pkt.tag)];
    tag_one_blocked = i_match[IRXMF_ACCEPT_TAG_ONE_GATE_BIT] && (i_pkt.tag == IRXMF_TAG_ONE)
      && (i_pkt.sync[3:2] != IRXMF_SYNC_TOP_OK);
    qual_ok = (i_qual_sel != IRXMF_QSEL_COMPARE)
      || (i_pkt.sync == i_match[IRXMF_QUAL_MSB:IRXMF_QUAL_LSB]);
    o_pass = chan_ok && tag_ok && !tag_one_blocked && qual_ok;
  end

endmodule : irxmf_ctx_filter

// >>> rtl/irxmf_top.sv
// Contract
// - bits 31/30 accept tags 11b/10b
// - bits 29/28 accept tags 01b/00b
// - match bits 27:25 read zero
// - match bit 7 reads zero
// - compare field: 13 bits, seconds bits compared as zero
// - gate opens when cycle timer equals compare
// - qualifier nibble compared when select is 11b
// - tag-one gate needs sync top bits 00b
// - other tags use own accept bits only
// - gate clear: tag bits alone decide
// - accept only the configured channel
// - pointer gives context program start address
// - eight contexts, 32-byte register stride
`timescale 1ns/100ps
module irxmf_top
  import irxmf_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [15:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  output logic [31:0] o_reg_rdata,
  input wire irxmf_pkt_t i_pkt,
  input wire irxmf_ctime_t i_ctime,
  input wire logic [IRXMF_NCTX-1:0] i_run,
  input wire logic [IRXMF_NCTX-1:0] i_gate_on,
  input wire logic [IRXMF_NCTX-1:0][1:0] i_qual_sel,
  output logic [IRXMF_NCTX-1:0] o_accept,
  output logic [IRXMF_NCTX-1:0] o_gate_open,
  output logic o_fetch_req,
  output logic [2:0] o_fetch_ctx,
  output logic [31:0] o_fetch_addr
);

  logic [IRXMF_NCTX-1:0][31:0] match;
  logic [IRXMF_NCTX-1:0][31:0] next_match;
  logic [IRXMF_NCTX-1:0][31:0] ptr;
  logic [IRXMF_NCTX-1:0][31:0] next_ptr;
  logic [31:0] next_rdata;
  logic [IRXMF_NCTX-1:0] next_gate_open;
  logic [IRXMF_NCTX-1:0] cmp_hit;
  logic [IRXMF_NCTX-1:0] pass;
  logic [IRXMF_NCTX-1:0] next_accept;
  logic [IRXMF_NCTX-1:0] run_q;
  logic [IRXMF_NCTX-1:0] pending;
  logic [IRXMF_NCTX-1:0] next_pending;
  logic [IRXMF_NCTX-1:0] served;
  logic next_fetch_req;
  logic [2:0] next_fetch_ctx;
  logic [31:0] next_fetch_addr;

  // register writes: one match and one pointer per context at a 32-byte stride
  always_comb begin
    next_match = match;
    next_ptr = ptr;
    for (int n = 0; n < IRXMF_NCTX; n++) begin
      if (i_reg_wr && i_reg_addr == IRXMF_MATCH_BASE + 16'(n) * IRXMF_STRIDE) begin
        next_match[n] = i_reg_wdata & IRXMF_MATCH_RMASK;
      end
      if (i_reg_wr && i_reg_addr == IRXMF_PTR_BASE + 16'(n) * IRXMF_STRIDE) begin
        next_ptr[n] = i_reg_wdata;
      end
    end
  end

  // register reads: data lands one cycle after the read strobe, unmapped reads zero
  always_comb begin
    next_rdata = o_reg_rdata;
    if (i_reg_rd) begin
      next_rdata = IRXMF_RDATA_IDLE;
      for (int n = 0; n < IRXMF_NCTX; n++) begin
        if (i_reg_addr == IRXMF_MATCH_BASE + 16'(n) * IRXMF_STRIDE) begin
          next_rdata = match[n] & IRXMF_MATCH_RMASK;
        end
        if (i_reg_addr == IRXMF_PTR_BASE + 16'(n) * IRXMF_STRIDE) begin
          next_rdata = ptr[n];
        end
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      match <= {IRXMF_NCTX{IRXMF_MATCH_RESET}};
      ptr <= {IRXMF_NCTX{IRXMF_PTR_RESET}};
      o_reg_rdata <= IRXMF_RDATA_IDLE;
    end else begin
      match <= next_match;
      ptr <= next_ptr;
      o_reg_rdata <= next_rdata;
    end
  end

  // per-context start gate and packet filter
  genvar g;
  generate
    for (g = 0; g < IRXMF_NCTX; g++) begin : g_ctx
      // compare field is zero-extended to the full cycle timer width
      assign cmp_hit[g] = (i_ctime == 15'(match[g][IRXMF_CMP_MSB:IRXMF_CMP_LSB]));
      irxmf_ctx_filter u_filter (
        .i_match(match[g]),
        .i_pkt(i_pkt),
        .i_qual_sel(i_qual_sel[g]),
        .o_pass(pass[g])
      );
    end
  endgenerate

  // gate closes when stopped, opens at once or on the matching cycle, then holds
  always_comb begin
    for (int n = 0; n < IRXMF_NCTX; n++) begin
      if (!i_run[n]) begin
        next_gate_open[n] = 1'b0;
      end else if (!i_gate_on[n] || cmp_hit[n]) begin
        next_gate_open[n] = 1'b1;
      end else begin
        next_gate_open[n] = o_gate_open[n];
      end
      next_accept[n] = i_pkt.valid && i_run[n] && o_gate_open[n] && pass[n];
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_gate_open <= '0;
      o_accept <= '0;
    end else begin
      o_gate_open <= next_gate_open;
      o_accept <= next_accept;
    end
  end

  // start requests: a run rise queues a fetch, lowest context served first
  always_comb begin
    served = '0;
    next_fetch_req = 1'b0;
    next_fetch_ctx = o_fetch_ctx;
    next_fetch_addr = o_fetch_addr;
    for (int n = IRXMF_NCTX - 1; n >= 0; n--) begin
      if (pending[n]) begin
        served = '0;
        served[n] = 1'b1;
        next_fetch_req = 1'b1;
        next_fetch_ctx = 3'(n);
        next_fetch_addr = ptr[n];
      end
    end
    next_pending = (pending & ~served) | (i_run & ~run_q); // new start wins over service
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_q <= '0;
      pending <= '0;
      o_fetch_req <= 1'b0;
      o_fetch_ctx <= '0;
      o_fetch_addr <= '0;
    end else begin
      run_q <= i_run;
      pending <= next_pending;
      o_fetch_req <= next_fetch_req;
      o_fetch_ctx <= next_fetch_ctx;
      o_fetch_addr <= next_fetch_addr;
    end
  end

  // checks on contexts 0 and 1
  logic ok0;
  assign ok0 = i_pkt.valid && i_run[0] && o_gate_open[0]
    && i_pkt.chan == match[0][IRXMF_CHAN_MSB:IRXMF_CHAN_LSB]
    && i_qual_sel[0] != IRXMF_QSEL_COMPARE;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  chk_reserved_high_zero: assert property (
    i_reg_rd && i_reg_addr == IRXMF_MATCH_BASE |=> o_reg_rdata[27:25] == 3'h0)
    else $error("reserved match bits 27:25 read nonzero");
  chk_reserved_bit_zero: assert property (
    i_reg_rd && i_reg_addr == IRXMF_MATCH_BASE |=> !o_reg_rdata[7])
    else $error("reserved match bit 7 read nonzero");
  chk_tag_three_off: assert property (
    ok0 && i_pkt.tag == 2'h3 && !match[0][IRXMF_TAG_THREE_BIT] |=> !o_accept[0])
    else $error("tag 11b accepted with its bit clear");
  chk_tag_zero_on: assert property (
    ok0 && i_pkt.tag == 2'h0 && match[0][IRXMF_TAG_ZERO_BIT] |=> o_accept[0])
    else $error("tag 00b refused with its bit set");
  chk_tag_one_qual: assert property (
    ok0 && i_pkt.tag == IRXMF_TAG_ONE && match[0][IRXMF_ACCEPT_TAG_ONE_GATE_BIT]
    && i_pkt.sync[3:2] != IRXMF_SYNC_TOP_OK |=> !o_accept[0])
    else $error("tag 01b accepted despite sync top bits");
  chk_other_tag_free: assert property (
    ok0 && i_pkt.tag == 2'h2 && match[0][IRXMF_TAG_TWO_BIT]
    && match[0][IRXMF_ACCEPT_TAG_ONE_GATE_BIT] |=> o_accept[0])
    else $error("tag 10b refused under tag-one gate");
  chk_gate_clear_free: assert property (
    ok0 && i_pkt.tag == IRXMF_TAG_ONE && match[0][IRXMF_TAG_ONE_BIT]
    && !match[0][IRXMF_ACCEPT_TAG_ONE_GATE_BIT] |=> o_accept[0])
    else $error("tag 01b refused with tag-one gate clear");
  chk_channel_only: assert property (
    i_pkt.chan != match[0][IRXMF_CHAN_MSB:IRXMF_CHAN_LSB] |=> !o_accept[0])
    else $error("packet accepted on wrong channel");
  chk_qualifier_cmp: assert property (
    i_qual_sel[0] == IRXMF_QSEL_COMPARE
    && i_pkt.sync != match[0][IRXMF_QUAL_MSB:IRXMF_QUAL_LSB] |=> !o_accept[0])
    else $error("qualifier mismatch accepted");
  chk_gate_waits: assert property (
    i_run[1] && i_gate_on[1] && !o_gate_open[1] && !cmp_hit[1] |=> !o_gate_open[1])
    else $error("gate opened before cycle match");
  chk_closed_gate: assert property (
    !o_gate_open[1] |=> !o_accept[1])
    else $error("packet accepted through closed gate");
  chk_start_fetch: assert property (
    $rose(i_run[0]) |-> ##2 (o_fetch_req && o_fetch_ctx == 3'h0))
    else $error("context 0 start did not fetch");

  cov_accept: cover property (o_accept[0]);
  cov_gate_match: cover property (i_gate_on[1] && $rose(o_gate_open[1]));
  cov_fetch: cover property (o_fetch_req);

endmodule : irxmf_top

// >>> verif/irxmf_link_model.sv
`timescale 1ns/100ps
module irxmf_link_model
  import irxmf_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_send,
  input wire logic [1:0] i_tag,
  input wire logic [5:0] i_chan,
  input wire logic [3:0] i_sync,
  output irxmf_pkt_t o_pkt
);
  // one header per request, valid for one cycle; idle fields toggle so no stale match
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pkt <= '0;
    end else if (i_send) begin
      o_pkt <= '{valid: 1'b1, tag: i_tag, chan: i_chan, sync: i_sync};
    end else begin
      o_pkt <= '{valid: 1'b0, tag: ~o_pkt.tag, chan: ~o_pkt.chan, sync: ~o_pkt.sync};
    end
  end
endmodule : irxmf_link_model

// >>> verif/iso_rx_context_match_filter_test.sv
`timescale 1ns/100ps
module iso_rx_context_match_filter_test
  import irxmf_pkg::*;
;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic wr = 1'b0, rd = 1'b0, send = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] tag = 2'h0;
  logic [5:0] chan = 6'h0;
  logic [3:0] sync = 4'h0;
  irxmf_pkt_t pkt;
  irxmf_ctime_t ctime = '0;
  logic [7:0] run = 8'h0, gate_on = 8'h0, accept, gate_open;
  logic [7:0][1:0] qual_sel = '0;
  logic fetch_req;
  logic [2:0] fetch_ctx;
  logic [31:0] fetch_addr;
  int n_errors = 0, cmp_count = 0, cycles = 0;

  // clock and cycle ceiling
  always #20 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors = n_errors + 1;
      close_out();
    end
  end

  irxmf_link_model i_link (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_send(send), .i_tag(tag),
    .i_chan(chan), .i_sync(sync), .o_pkt(pkt));
  irxmf_top i_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_pkt(pkt),
    .i_ctime(ctime), .i_run(run), .i_gate_on(gate_on), .i_qual_sel(qual_sel),
    .o_accept(accept), .o_gate_open(gate_open), .o_fetch_req(fetch_req),
    .o_fetch_ctx(fetch_ctx), .o_fetch_addr(fetch_addr));

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic reg_wr(logic [15:0] a, logic [31:0] d);
    @(posedge i_mclk) begin wr <= 1'b1; addr <= a; wdata <= d; end
    @(posedge i_mclk) wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(logic [15:0] a, logic [31:0] exp);
    @(posedge i_mclk) begin rd <= 1'b1; addr <= a; end
    @(posedge i_mclk) rd <= 1'b0;
    #1 check("read data", rdata, exp);
  endtask : reg_rd

  // header leaves the link model one edge later, accept shows after the next edge
  task automatic send_pkt(logic [1:0] t, logic [5:0] c, logic [3:0] s, logic [7:0] exp);
    @(posedge i_mclk) begin send <= 1'b1; tag <= t; chan <= c; sync <= s; end
    @(posedge i_mclk) send <= 1'b0;
    @(posedge i_mclk) #1 check("accept", {24'h0, accept}, {24'h0, exp});
  endtask : send_pkt

  task automatic test_regs();
    reg_rd(16'h410c, 32'h0);
    reg_wr(16'h410c, 32'hffff_ffff);
    reg_rd(16'h410c, 32'hf1ff_ff7f);
    reg_wr(16'h416c, 32'hffff_ffff);
    reg_rd(16'h416c, 32'hf1ff_ff7f);
    reg_wr(16'h046c, 32'h1234_5678);
    reg_rd(16'h046c, 32'h1234_5678);
    reg_rd(16'h0400, 32'h0);
    $display("registers done");
  endtask : test_regs

  task automatic test_tags();
    @(posedge i_mclk) run[0] <= 1'b1;
    for (int b = 0; b < 4; b++) begin
      reg_wr(16'h410c, (32'h1 << (28 + b)) | 32'h5);
      for (int t = 0; t < 4; t++) send_pkt(2'(t), 6'h05, 4'hf, {7'h0, t == b});
      send_pkt(2'(b), 6'h06, 4'h0, 8'h00);
    end
    $display("tag select done");
  endtask : test_tags

  task automatic test_qualifiers();
    reg_wr(16'h410c, 32'h7000_0a45);
    send_pkt(2'h1, 6'h05, 4'h3, 8'h01);
    send_pkt(2'h1, 6'h05, 4'h4, 8'h00);
    send_pkt(2'h0, 6'h05, 4'hc, 8'h01);
    send_pkt(2'h2, 6'h05, 4'hc, 8'h01);
    @(posedge i_mclk) qual_sel[0] <= 2'h3;
    send_pkt(2'h0, 6'h05, 4'ha, 8'h01);
    send_pkt(2'h0, 6'h05, 4'hb, 8'h00);
    @(posedge i_mclk) qual_sel[0] <= 2'h0;
    $display("qualifiers done");
  endtask : test_qualifiers

  task automatic test_start_gate();
    int k;
    reg_wr(16'h410c, 32'h0000_0009);
    reg_wr(16'h042c, 32'hcafe_0040);
    reg_wr(16'h412c, 32'h1012_3005);
    @(posedge i_mclk) begin gate_on[1] <= 1'b1; run[1] <= 1'b1; end
    k = 0;
    while (fetch_req !== 1'b1 && k < 8) begin @(posedge i_mclk); #1 k++; end
    check("fetch req", {31'h0, fetch_req}, 32'h1);
    check("fetch ctx", {29'h0, fetch_ctx}, 32'h1);
    check("fetch addr", fetch_addr, 32'hcafe_0040);
    check("gate shut", {31'h0, gate_open[1]}, 32'h0);
    @(posedge i_mclk) #1 check("fetch req drop", {31'h0, fetch_req}, 32'h0);
    send_pkt(2'h0, 6'h05, 4'h0, 8'h00);
    @(posedge i_mclk) ctime <= 15'h0123;
    @(posedge i_mclk) ctime <= 15'h0000;
    repeat (2) @(posedge i_mclk);
    #1 check("gate open", {31'h0, gate_open[1]}, 32'h1);
    send_pkt(2'h0, 6'h05, 4'h0, 8'h02);
    $display("start gate done");
  endtask : test_start_gate

  initial begin
    repeat (20) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    test_regs();
    test_tags();
    test_qualifiers();
    test_start_gate();
    close_out();
  end
endmodule : iso_rx_context_match_filter_test
